/* src/stair_pkg.sv */
// Package of constants for the staircase up/down decimal counter generator
// What this block does
// - Presettable decimal counter, up or down, one step per step_in pulse
// - Terminal carry falls at upward final count
// - Inverted carry clocks the direction flip-flop
// - Toggle after top switches to counting down
// - Carry falls at zero, direction back up
// - Direction stage toggles from its inverted output
package stair_pkg;
  localparam int          DIGIT_W   = 4;      // Width of one decimal digit
  localparam logic [3:0]  COUNT_MIN = 4'h0;   // Lowest step of the staircase
  localparam logic [3:0]  COUNT_MAX = 4'h9;   // Final count of a decade
  localparam logic [3:0]  COUNT_RST = 4'h0;   // Count after reset
  localparam logic        DIR_UP    = 1'b1;   // Direction code for upward
  localparam logic        DIR_RST   = 1'b1;   // Direction after reset (up)
  localparam logic        CARRY_IDLE = 1'b1;  // Carry level when not terminal
endpackage

/* src/dir_toggle.sv */
// Direction flip-flop built as a toggle stage on a clock enable
`timescale 1ns/10ps
`default_nettype none
module dir_toggle (
  input  wire logic clk_sys_in,   // System clock
  input  wire logic rstn_in,      // Asynchronous reset, active low
  input  wire logic tick_in,      // One-cycle enable: inverted carry edge
  output logic      dir_out       // Stored direction, 1 = up
);
  import stair_pkg::*;
  logic dir_reg;                  // Stored direction
  logic dir_next;                 // Next direction

  // Inverted output fed back as data on each enable
  always_comb begin
    dir_next = dir_reg;
    if (tick_in) begin
      dir_next = ~dir_reg;
    end
  end

  // Register the direction
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dir_reg <= DIR_RST;
    end else begin
      dir_reg <= dir_next;
    end
  end

  assign dir_out = dir_reg;
endmodule
`default_nettype wire

/* src/stair_gen.sv */
// Staircase generator: decimal up/down counter with self-reversing direction
`timescale 1ns/10ps
`default_nettype none
module stair_gen (
  input  wire logic                             clk_sys_in,   // System clock, 125 MHz
  input  wire logic                             rstn_in,      // Asynchronous reset, active low
  input  wire logic                             step_in,      // Count enable, one step per pulse
  input  wire logic                             load_in,      // Preset strobe
  input  wire logic [stair_pkg::DIGIT_W-1:0]    preset_in,    // Preset value (0..9)
  output logic      [stair_pkg::DIGIT_W-1:0]    count_out,    // Staircase step value
  output logic                                  carry_n_out,  // Terminal carry, active low
  output logic                                  dir_up_out    // Direction, 1 = counting up
);
  import stair_pkg::*;

  logic [DIGIT_W-1:0] count_reg;     // Counter state
  logic [DIGIT_W-1:0] count_next;    // Next counter state
  logic               carry_n_reg;   // Registered terminal carry
  logic               carry_n_next;  // Next terminal carry
  logic               carry_prev_reg;// Carry delayed for edge detect
  logic               carry_fall;    // Inverted carry edge, one cycle
  logic               dir;           // Current direction from toggle stage
  logic               dir_q_reg;     // Registered copy for the output
  logic               terminal;      // Count at end of current direction

  // Terminal state depends on direction: top going up, zero going down
  always_comb begin
    if (dir == DIR_UP) begin
      terminal = (count_reg == COUNT_MAX);
    end else begin
      terminal = (count_reg == COUNT_MIN);
    end
  end

  // Counter next state: preset, else step by direction
  always_comb begin
    count_next   = count_reg;
    carry_n_next = ~terminal;
    if (load_in) begin
      if (preset_in > COUNT_MAX) begin
        count_next = COUNT_MAX;                    // Clamp illegal preset
      end else begin
        count_next = preset_in;
      end
    end else if (step_in) begin
      if (dir == DIR_UP) begin
        if (count_reg >= COUNT_MAX) begin
          count_next = COUNT_MIN;                  // Decade wrap
        end else begin
          count_next = count_reg + 4'h1;
        end
      end else begin
        if (count_reg == COUNT_MIN) begin
          count_next = COUNT_MAX;                  // Decade wrap
        end else begin
          count_next = count_reg - 4'h1;
        end
      end
    end
  end

  // Falling carry inverted becomes one-cycle toggle enable
  assign carry_fall = carry_prev_reg & ~carry_n_reg;

  // Register counter and carry state
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_reg      <= COUNT_RST;
      carry_n_reg    <= CARRY_IDLE;
      carry_prev_reg <= CARRY_IDLE;
      dir_q_reg      <= DIR_RST;
    end else begin
      count_reg      <= count_next;
      carry_n_reg    <= carry_n_next;
      carry_prev_reg <= carry_n_reg;
      dir_q_reg      <= dir;
    end
  end

  // Direction flip-flop clocked by inverted carry edge
  dir_toggle u_dir (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .tick_in    (carry_fall),
    .dir_out    (dir)
  );

  assign count_out   = count_reg;
  assign carry_n_out = carry_n_reg;
  assign dir_up_out  = dir_q_reg;

  // Carry low the cycle after the count is terminal in the current direction
  a_carry_top: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (dir && count_reg == COUNT_MAX && !load_in) |=> !carry_n_reg)
    else $error("carry did not fall at top count");

  a_carry_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (!dir && count_reg == COUNT_MIN && !load_in) |=> !carry_n_reg)
    else $error("carry did not fall at zero");

  sequence s_fall;
    carry_prev_reg && !carry_n_reg;
  endsequence

  a_dir_flip: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    s_fall |=> (dir != $past(dir)))
    else $error("direction did not toggle on carry fall");

  a_dir_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    !carry_fall |=> (dir == $past(dir)))
    else $error("direction changed without carry fall");

  a_up_to_down: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (s_fall and (dir && count_reg == COUNT_MAX)) |=> !dir)
    else $error("no switch to down after top");

  a_step_up: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (step_in && !load_in && dir && count_reg < COUNT_MAX) |=> count_reg == $past(count_reg) + 4'h1)
    else $error("upward step wrong");

  a_step_down: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (step_in && !load_in && !dir && count_reg > COUNT_MIN) |=> count_reg == $past(count_reg) - 4'h1)
    else $error("downward step wrong");

  a_decimal: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    count_reg <= COUNT_MAX)
    else $error("count left decimal range");

  // Named steps of the staircase, reused by the checks below
  // Terminal points per direction, and the input cases that move or hold the count
  // Preset beyond nine is split out since it clamps
  sequence s_top_up;
    dir && count_reg == COUNT_MAX;
  endsequence

  sequence s_zero_down;
    !dir && count_reg == COUNT_MIN;
  endsequence

  sequence s_step_only;
    step_in && !load_in;
  endsequence

  sequence s_idle;
    !step_in && !load_in;
  endsequence

  sequence s_load_ok;
    load_in && preset_in <= COUNT_MAX;
  endsequence

  sequence s_load_big;
    load_in && preset_in > COUNT_MAX;
  endsequence

  // Carry back high once the step is no longer terminal for the current direction
  a_carry_rise: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    !terminal |=> carry_n_reg)
    else $error("carry stayed low off the terminal step");

  // Fall at zero while counting down turns counting back up
  a_down_to_up: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (s_fall and s_zero_down) |=> dir)
    else $error("no switch to up after zero");

  // Legal preset lands as given
  a_load_take: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    s_load_ok |=> count_reg == $past(preset_in))
    else $error("preset not loaded");

  // Preset beyond nine clamps to the top step
  a_load_clamp: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    s_load_big |=> count_reg == COUNT_MAX)
    else $error("oversized preset not clamped");

  // Preset wins over a step in the same cycle
  a_load_first: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (s_load_ok and step_in) |=> count_reg == $past(preset_in))
    else $error("step overrode preset");

  // No step and no preset keeps the count
  a_hold_idle: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    s_idle |=> $stable(count_reg))
    else $error("count moved without a step");

  // Step past the top before the flip wraps to zero
  a_wrap_up: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (s_step_only and s_top_up) |=> count_reg == COUNT_MIN)
    else $error("upward wrap wrong");

  // Step past zero before the flip wraps to nine
  a_wrap_down: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (s_step_only and s_zero_down) |=> count_reg == COUNT_MAX)
    else $error("downward wrap wrong");

  // Direction output trails the toggle stage by one cycle
  a_dir_lag: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    dir_q_reg == $past(dir))
    else $error("direction output does not follow");

  // Toggle enable is a single-cycle pulse
  a_fall_once: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    s_fall |=> !carry_fall)
    else $error("toggle enable longer than one cycle");

  // Any direction change was caused by a carry fall
  a_toggle_src: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (dir != $past(dir)) |-> $past(carry_fall))
    else $error("direction changed with no carry fall");

  // Toggle enable only while the carry is low
  a_fall_low: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    carry_fall |-> !carry_n_reg)
    else $error("toggle enable with carry high");

  // Carry fall only follows a terminal step
  a_fall_term: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    s_fall |-> $past(terminal))
    else $error("carry fell off a terminal step");
endmodule
`default_nettype wire

/* test/stair_step_src.sv */
// Step pulse source that stands in for the external counting clock
`timescale 1ns/10ps
`default_nettype none
module stair_step_src #(
  parameter int GAP = 5                // Cycles between steps
) (
  input  wire logic clk_sys_in,        // System clock
  input  wire logic rstn_in,           // Reset, active low
  input  wire logic run_in,            // Enables the pulse train
  output logic      step_out           // One-cycle step pulse
);
  logic [3:0] gap_reg;                 // Cycles since last pulse
  // Wide spacing leaves room for the direction flip after a terminal count
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gap_reg  <= 4'h0;
      step_out <= 1'b0;
    end else begin
      gap_reg  <= (gap_reg == GAP[3:0] - 4'h1) ? 4'h0 : gap_reg + 4'h1;
      step_out <= run_in && (gap_reg == 4'h0);
    end
  end
endmodule
`default_nettype wire

/* test/stair_gen_test.sv */
// Self-checking bench for the staircase generator
`timescale 1ns/10ps
`default_nettype none
module stair_gen_test;
  import stair_pkg::*;
  logic       clk_sys_in = 1'b0;       // System clock
  logic       rstn_in = 1'b0;          // Reset, active low
  logic       load_in = 1'b0;          // Preset strobe
  logic       run = 1'b0;              // Step source enable
  logic [3:0] preset_in = 4'h0;        // Preset value
  logic [3:0] exp_cnt = 4'h0;          // Expected step value
  logic       exp_up = 1'b1;           // Expected direction
  logic       step_in;                 // Step pulse from the source
  logic [3:0] count_out;               // Step value seen
  logic       carry_n_out;             // Terminal carry seen
  logic       dir_up_out;              // Direction seen
  int         n_errors = 0;            // Mismatches
  int         n_compared = 0;          // Comparisons made
  stair_gen dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .step_in(step_in), .load_in(load_in),
    .preset_in(preset_in), .count_out(count_out), .carry_n_out(carry_n_out), .dir_up_out(dir_up_out));
  stair_step_src src (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .run_in(run), .step_out(step_in));
  // 125 MHz clock
  initial forever #4 clk_sys_in = ~clk_sys_in;
  // Compare and count
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic test_done();
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Reset held six cycles, then outputs at their start values
  task automatic do_reset();
    @(posedge clk_sys_in) rstn_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    check("count", count_out, 4'h0);
    check("dir", {3'h0, dir_up_out}, 4'h1);
    check("carry_n", {3'h0, carry_n_out}, 4'h1);
    rstn_in <= 1'b1;
    exp_cnt = 4'h0;
    exp_up  = 1'b1;
  endtask
  // One step taken; direction and count judged, carry one cycle later
  task automatic take_step();
    logic term;
    do @(posedge clk_sys_in); while (step_in !== 1'b1);
    #1;
    check("dir", {3'h0, dir_up_out}, {3'h0, exp_up});
    exp_cnt = exp_up ? exp_cnt + 4'h1 : exp_cnt - 4'h1;
    term = exp_up ? (exp_cnt == COUNT_MAX) : (exp_cnt == COUNT_MIN);
    check("count", count_out, exp_cnt);
    @(posedge clk_sys_in);
    #1;
    check("carry_n", {3'h0, carry_n_out}, {3'h0, !term});
    if (term) exp_up = !exp_up;
  endtask
  // Preset load, out-of-range value clamps to the top
  task automatic load_chk(input logic [3:0] val, input logic [3:0] exp);
    @(posedge clk_sys_in);
    load_in   <= 1'b1;
    preset_in <= val;
    @(posedge clk_sys_in);
    load_in <= 1'b0;
    #1;
    check("preset", count_out, exp);
  endtask
  // Full staircase up, down and up again, then presets and a second reset
  initial begin
    do_reset();
    @(posedge clk_sys_in) run <= 1'b1;
    repeat (20) take_step();
    @(posedge clk_sys_in) run <= 1'b0;
    load_chk(4'h7, 4'h7);
    load_chk(4'hF, COUNT_MAX);
    do_reset();
    test_done();
  end
  // Hang guard
  initial begin
    #20000;
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
